// >>> gpmw_map.vh
// Purpose: Constants for the pin multiplexer and wake-up front end
// Assumes: 100 MHz system clock
// Notes: Test codes are sampled on port 0 bits 3:0
`ifndef GPMW_MAP_VH
`define GPMW_MAP_VH
`define GPMW_NPINS 18
`define GPMW_CLK_MHZ 100
`define GPMW_TEST_HOLD_US 10
`define GPMW_TEST_HOLD_CYC (`GPMW_TEST_HOLD_US * `GPMW_CLK_MHZ + 1)
`define GPMW_CODE_OTP 4'h0
`define GPMW_CODE_FLASH 4'h1
`define GPMW_CODE_RADIO 4'h3
`define GPMW_DBG_OFF 8'h00
`define GPMW_WAKE_EN_BIT 1
`define GPMW_WAKE_EDGE_BIT 0
`define GPMW_FILT_MATCH 3
`define GPMW_PULL_NONE 2'h0
`define GPMW_PULL_UP 2'h1
`define GPMW_PULL_DOWN 2'h2
`define GPMW_PULL_OFF 2'h3
`endif

// >>> gpmw_filter.v
// Purpose: Per-pin synchroniser and optional glitch filter
// Assumes: Raw pin levels are asynchronous to sys_clk
// Notes: Filtered level changes after three matching samples
`timescale 1ns/1ps
`default_nettype none
`include "gpmw_map.vh"
module gpmw_filter #(
  parameter WIDTH = 18
) (
  input wire sys_clk,
  input wire rst,
  input wire [WIDTH-1:0] pin_raw,
  input wire [WIDTH-1:0] pin_filter_enable,
  output wire [WIDTH-1:0] pin_clean
);
  reg [WIDTH-1:0] meta_q; // First synchroniser stage
  reg [WIDTH-1:0] sync_q; // Second synchroniser stage
  reg [WIDTH-1:0] hist1_q; // One sample older
  reg [WIDTH-1:0] hist2_q; // Two samples older
  reg [WIDTH-1:0] level_q; // Accepted filtered level
  integer i;
  ////////////////////////////////////////////////////////////////////////
  // Synchronise, shift history, accept on three matches
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
      hist1_q <= {WIDTH{1'b0}};
      hist2_q <= {WIDTH{1'b0}};
      level_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      hist1_q <= sync_q;
      hist2_q <= hist1_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        // Three equal samples replace the held level
        if (sync_q[i] == hist1_q[i] && hist1_q[i] == hist2_q[i]) begin
          level_q[i] <= sync_q[i];
        end
      end
    end
  end
  // Bypass selects the plain synchronised level per pin
  assign pin_clean = (pin_filter_enable & level_q) | (~pin_filter_enable & sync_q);
endmodule // gpmw_filter
`default_nettype wire

// >>> gpmw_pin_mux.v
// Purpose: Pin multiplexer, GPIO front end, wake-up and test-mode routing
// Assumes: Pins 0-7 port 0, 8-15 port 1, 16-17 port 2
// Notes: Peripheral priority arbitration lives outside this block
`timescale 1ns/1ps
`default_nettype none
`include "gpmw_map.vh"
module gpmw_pin_mux #(
  parameter NPINS = `GPMW_NPINS
) (
  input wire sys_clk,
  input wire rst,
  // Pad side
  input wire [NPINS-1:0] pin_in,
  output reg [NPINS-1:0] pin_out,
  output reg [NPINS-1:0] pin_oe,
  output reg [NPINS-1:0] pin_high_drive,
  output reg [NPINS-1:0] pin_in_enable,
  output reg [NPINS-1:0] pin_pull_up,
  output reg [NPINS-1:0] pin_pull_down,
  input wire test_pin,
  // Processor GPIO side
  input wire [NPINS-1:0] gpio_data_out,
  input wire [NPINS-1:0] gpio_dir_out,
  input wire [NPINS-1:0] gpio_high_drive,
  input wire [2*NPINS-1:0] gpio_pull_mode,
  input wire [NPINS-1:0] pin_filter_enable,
  input wire [2*NPINS-1:0] pin_wake_control,
  input wire [7:0] debug_select_port0,
  input wire [7:0] debug_select_port1,
  output reg [NPINS-1:0] gpio_data_in,
  output reg wake_request,
  // Peripheral side: generic takeover per pin
  input wire [NPINS-1:0] periph_own,
  input wire [NPINS-1:0] periph_out,
  input wire [NPINS-1:0] periph_oe,
  // Debug routing for ports 0 and 1
  input wire [15:0] debug_out,
  input wire [15:0] debug_oe,
  // Master SPI
  input wire master_spi_enable,
  input wire master_spi_data_out,
  input wire master_spi_data_oe,
  input wire master_spi_clock_out,
  input wire master_spi_select_out,
  output reg master_spi_data_in,
  // OTP slave SPI
  output reg otp_spi_active,
  output reg otp_spi_clock_in,
  output reg otp_spi_select_in,
  output reg otp_spi_data_in,
  input wire otp_spi_data_out,
  // Serial flash master SPI
  output reg flash_spi_active,
  input wire flash_spi_clock_out,
  input wire flash_spi_select_out,
  input wire flash_spi_data_out,
  output reg flash_spi_data_in,
  // Radio SPI
  output reg radio_spi_active,
  output reg radio_spi_clock_in,
  output reg radio_spi_select_in,
  output reg radio_spi_data_in,
  output reg radio_chip_enable_in,
  input wire radio_spi_data_out,
  input wire radio_interrupt_out
);
  // Full-width hold count, cut on purpose to the width of the hold counter
  localparam HOLD_FULL = `GPMW_TEST_HOLD_CYC;
  localparam [15:0] HOLD_CYC = HOLD_FULL[15:0];
  // Test-mode states
  localparam [1:0] ST_NONE = 2'h0; // Normal multiplexing
  localparam [1:0] ST_OTP = 2'h1; // Slave SPI into the programmable memory
  localparam [1:0] ST_FLASH = 2'h2; // Master SPI out to a serial flash
  localparam [1:0] ST_RADIO = 2'h3; // Radio SPI brought out to port 1
  wire [NPINS-1:0] clean; // Synchronised, optionally filtered inputs
  reg test_meta_q; // Test pin first stage
  reg test_sync_q; // Test pin second stage
  reg [NPINS-1:0] prev_q; // Last clean level for edge detect
  reg [3:0] code_q; // Code seen last cycle
  reg [15:0] hold_q; // Cycles the code has held
  reg [1:0] state_q; // Active test routing
  reg [1:0] state_d;
  reg wake_d; // Any enabled pin shows its edge this cycle
  reg [2:0] settle_q; // Cycles since reset, saturating
  wire settled; // Inputs have passed the synchroniser and filter
  reg debug_on; // Ports 0 and 1 diverted to debug
  integer i;
  ////////////////////////////////////////////////////////////////////////
  // Input synchroniser and filter
  gpmw_filter #(
    .WIDTH(NPINS)
  ) u_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_raw(pin_in),
    .pin_filter_enable(pin_filter_enable),
    .pin_clean(clean)
  );
  // Maps a test code to its routing state
  function [1:0] code_state;
    input [3:0] code;
    begin
      if (code == `GPMW_CODE_OTP) code_state = ST_OTP;
      else if (code == `GPMW_CODE_FLASH) code_state = ST_FLASH;
      else if (code == `GPMW_CODE_RADIO) code_state = ST_RADIO;
      else code_state = ST_NONE;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Edge detection is held off until the clean levels have settled.
  // The edge history resets low, so a pin idling high behind a pull-up
  // would otherwise look like a rising edge just after reset and
  // raise a spurious wake request.
  assign settled = (settle_q == 3'h7);
  ////////////////////////////////////////////////////////////////////////
  // Wake edge detection on the clean level
  // Each pin compares its clean level against last cycle's; the
  // enable bit gates the pin and the edge bit picks the direction.
  always @* begin
    wake_d = 1'b0;
    for (i = 0; i < NPINS; i = i + 1) begin
      if (settled && pin_wake_control[2*i+`GPMW_WAKE_EN_BIT]) begin
        if (pin_wake_control[2*i+`GPMW_WAKE_EDGE_BIT]) begin
          if (prev_q[i] && !clean[i]) wake_d = 1'b1;
        end else begin
          if (!prev_q[i] && clean[i]) wake_d = 1'b1;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Test-mode code qualification
  // A code must stand, with the test pin high, for the whole hold
  // time before its routing is granted. Any change of code or a low
  // test pin drops the routing at once, so a tester that is moving
  // port 0 can never leave half-routed pins behind.
  always @* begin
    state_d = state_q;
    if (!test_sync_q || clean[3:0] != code_q) begin
      state_d = ST_NONE;
    end else if (hold_q >= HOLD_CYC) begin
      state_d = code_state(code_q);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Registered state
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      test_meta_q <= 1'b0;
      test_sync_q <= 1'b0;
      prev_q <= {NPINS{1'b0}};
      code_q <= 4'hf;
      hold_q <= 16'h0000;
      state_q <= ST_NONE;
      wake_request <= 1'b0;
      gpio_data_in <= {NPINS{1'b0}};
      settle_q <= 3'h0;
    end else begin
      // Count out the synchroniser and filter latency once after reset
      if (!settled) begin
        settle_q <= settle_q + 3'h1;
      end
      test_meta_q <= test_pin;
      test_sync_q <= test_meta_q;
      prev_q <= clean;
      code_q <= clean[3:0];
      // Count while the pin is high and the code steady
      if (!test_sync_q || clean[3:0] != code_q) begin
        hold_q <= 16'h0000;
      end else if (hold_q < HOLD_CYC) begin
        hold_q <= hold_q + 16'h0001;
      end
      state_q <= state_d;
      wake_request <= wake_d;
      gpio_data_in <= clean;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Pad drive and routing, by rising priority
  // Later assignments override earlier ones: processor GPIO first,
  // then peripheral takeover, master SPI, debug, and test mode last.
  // Pull and input-buffer settings stay with the processor, since the
  // peripherals here only claim data and direction.
  // Every output gets a default at the top so no latch is inferred.
  always @* begin
    debug_on = (debug_select_port0 != `GPMW_DBG_OFF) ||
      (debug_select_port1 != `GPMW_DBG_OFF);
    pin_out = {NPINS{1'b0}};
    pin_oe = {NPINS{1'b0}};
    pin_high_drive = {NPINS{1'b0}};
    pin_in_enable = {NPINS{1'b1}};
    pin_pull_up = {NPINS{1'b0}};
    pin_pull_down = {NPINS{1'b0}};
    for (i = 0; i < NPINS; i = i + 1) begin
      // Default processor GPIO; reset inputs leave dir low
      pin_out[i] = gpio_data_out[i];
      pin_oe[i] = gpio_dir_out[i];
      pin_high_drive[i] = gpio_dir_out[i] & gpio_high_drive[i];
      case (gpio_pull_mode[2*i+:2])
        `GPMW_PULL_UP: pin_pull_up[i] = 1'b1;
        `GPMW_PULL_DOWN: pin_pull_down[i] = 1'b1;
        `GPMW_PULL_OFF: pin_in_enable[i] = 1'b0;
        default: pin_in_enable[i] = 1'b1;
      endcase
      if (periph_own[i]) begin
        pin_out[i] = periph_out[i];
        pin_oe[i] = periph_oe[i];
      end
    end
    if (master_spi_enable) begin
      pin_oe[15] = 1'b0;
      pin_out[14] = master_spi_data_out;
      pin_oe[14] = master_spi_data_oe;
      pin_out[13] = master_spi_clock_out;
      pin_oe[13] = 1'b1;
      pin_out[12] = master_spi_select_out;
      pin_oe[12] = 1'b1;
    end
    if (debug_on) begin
      pin_out[15:0] = debug_out;
      pin_oe[15:0] = debug_oe;
    end
    case (state_q)
      ST_OTP: begin
        pin_oe[7:5] = 3'h0;
        pin_out[8] = otp_spi_data_out;
        pin_oe[8] = 1'b1;
      end
      ST_FLASH: begin
        pin_out[7] = flash_spi_data_out;
        pin_out[6] = flash_spi_select_out;
        pin_out[5] = flash_spi_clock_out;
        pin_oe[7:5] = 3'h7;
        pin_oe[8] = 1'b0;
      end
      ST_RADIO: begin
        pin_oe[15:13] = 3'h0;
        pin_oe[11] = 1'b0;
        pin_out[12] = radio_spi_data_out;
        pin_oe[12] = 1'b1;
        pin_out[9] = radio_interrupt_out;
        pin_oe[9] = 1'b1;
      end
      default: begin
        pin_oe[0] = pin_oe[0];
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // Peripheral-facing inputs, gated by their mode
  // Inactive interfaces see clock and data low and select high, so a
  // pin wiggling in normal use never looks like an SPI transfer.
  always @* begin
    master_spi_data_in = master_spi_enable & clean[15];
    otp_spi_active = (state_q == ST_OTP);
    flash_spi_active = (state_q == ST_FLASH);
    radio_spi_active = (state_q == ST_RADIO);
    otp_spi_clock_in = otp_spi_active & clean[5];
    otp_spi_select_in = otp_spi_active ? clean[6] : 1'b1;
    otp_spi_data_in = otp_spi_active & clean[7];
    flash_spi_data_in = flash_spi_active & clean[8];
    radio_spi_clock_in = radio_spi_active & clean[15];
    radio_spi_select_in = radio_spi_active ? clean[14] : 1'b1;
    radio_spi_data_in = radio_spi_active & clean[13];
    radio_chip_enable_in = radio_spi_active & clean[11];
  end
endmodule // gpmw_pin_mux
`default_nettype wire

// >>> gpmw_pads.sv
// Purpose: Pad model for the tester side of the pins
// Assumes: Device drive wins over the tester
// Notes: An undriven pad without a pull toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module gpmw_pads (
  input wire logic sys_clk,
  input wire logic [17:0] pin_out,
  input wire logic [17:0] pin_oe,
  input wire logic [17:0] pin_pull_up,
  input wire logic [17:0] pin_pull_down,
  input wire logic [17:0] ext_en,
  input wire logic [17:0] ext_val,
  output logic [17:0] pin_in
);
  logic flip_q = 1'b0; // Level on floating pads
  // Floating pattern so no stale level survives a release
  always @(posedge sys_clk) begin
    flip_q <= ~flip_q;
  end
  // Resolve each pad: device, tester, pull resistor, then float
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en &
    (pin_pull_up | (~pin_pull_down & {18{flip_q}})))));
endmodule // gpmw_pads
`default_nettype wire

// >>> gpmw_pin_mux_chk.sv
// Purpose: Port checker for the pin multiplexer
// Assumes: One clock, reset asynchronous and active high
// Notes: Bound to every pin multiplexer instance
`timescale 1ns/1ps
`default_nettype none
module gpmw_chk #(parameter NPINS = 18) (
  input wire sys_clk, rst, test_pin, wake_request, master_spi_enable, master_spi_data_oe,
  input wire master_spi_clock_out, master_spi_select_out, otp_spi_active, otp_spi_data_out,
  input wire flash_spi_active, flash_spi_clock_out, flash_spi_select_out, flash_spi_data_out,
  input wire radio_spi_active, radio_spi_data_out, radio_interrupt_out,
  input wire [NPINS-1:0] pin_out, pin_oe, gpio_data_out, gpio_dir_out, gpio_data_in, periph_own,
  input wire [2*NPINS-1:0] pin_wake_control,
  input wire [7:0] debug_select_port0, debug_select_port1,
  input wire [15:0] debug_out, debug_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [NPINS-1:0] din_q, en, fs; // Last data in, wake enables, edge selects
  logic [10:0] hi_q; // Cycles with the test pin high
  wire act = otp_spi_active | flash_spi_active | radio_spi_active;
  wire dbg = |{debug_select_port0, debug_select_port1};
  // History for edge and hold checks
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      din_q <= {NPINS{1'b0}};
      hi_q <= 11'h000;
    end else begin
      din_q <= gpio_data_in;
      hi_q <= !test_pin ? 11'h000 : hi_q + {10'h000, hi_q != 11'h7ff};
    end
  end
  // Split the wake controls into enable and edge bits
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      en[i] = pin_wake_control[2*i+1];
      fs[i] = pin_wake_control[2*i];
    end
  end
  wire hit = |(en & ((~fs & gpio_data_in & ~din_q) | (fs & ~gpio_data_in & din_q)));
  property p_wake; hit |-> ##[0:2] wake_request; endproperty
  a_wake: assert property (p_wake) else $error("Wake pulse missing");
  property p_wake_off; !(|en) [*4] |=> !wake_request; endproperty
  a_wake_off: assert property (p_wake_off) else $error("Wake while disabled");
  property p_hold; $rose(act) |-> hi_q >= 11'h3e8; endproperty
  a_hold: assert property (p_hold) else $error("Test mode entered early");
  property p_release; !test_pin [*4] |-> !act; endproperty
  a_release: assert property (p_release) else $error("Test mode kept");
  property p_otp; otp_spi_active |-> pin_oe[8] && pin_out[8] == otp_spi_data_out; endproperty
  a_otp: assert property (p_otp) else $error("Slave data out misrouted");
  property p_flash; flash_spi_active |-> pin_oe[7:5] == 3'h7 &&
    pin_out[7:5] == {flash_spi_data_out, flash_spi_select_out, flash_spi_clock_out}; endproperty
  a_flash: assert property (p_flash) else $error("Flash pins misrouted");
  property p_radio; radio_spi_active |-> pin_oe[12] && pin_oe[9] &&
    pin_out[12] == radio_spi_data_out && pin_out[9] == radio_interrupt_out; endproperty
  a_radio: assert property (p_radio) else $error("Radio pins misrouted");
  property p_debug; dbg && !act |-> pin_oe[15:0] == debug_oe &&
    ((pin_out[15:0] ^ debug_out) & debug_oe) == 16'h0000; endproperty
  a_debug: assert property (p_debug) else $error("Debug routing wrong");
  property p_gpio; !dbg && !act && !master_spi_enable |-> ~|((pin_oe ^ gpio_dir_out) &
    ~periph_own) && ~|((pin_out ^ gpio_data_out) & gpio_dir_out & ~periph_own); endproperty
  a_gpio: assert property (p_gpio) else $error("GPIO routing wrong");
  property p_master; master_spi_enable && !dbg && !act |-> pin_oe[15:12] ==
    {1'b0, master_spi_data_oe, 2'h3} &&
    pin_out[13:12] == {master_spi_clock_out, master_spi_select_out}; endproperty
  a_master: assert property (p_master) else $error("Master pins wrong");
  c_flash: cover property ($rose(flash_spi_active));
  c_radio: cover property ($rose(radio_spi_active));
  c_wake: cover property (wake_request && !act);
endmodule // gpmw_chk
bind gpmw_pin_mux gpmw_chk #(.NPINS(NPINS)) u_chk (.*);
`default_nettype wire

// >>> test_gpmw_pin_mux.sv
// Purpose: Self-checking bench for the pin multiplexer
// Assumes: 100 MHz clock, tester drives the pads
// Notes: Random routing, wake edges, filter, debug and test entry
`timescale 1ns/1ps
`default_nettype none
module test_gpmw_pin_mux;
  logic sys_clk = 1'b0, rst = 1'b1, test_pin = 1'b0, master_spi_enable, master_spi_data_oe;
  logic [17:0] pin_in, pin_out, pin_oe, pin_high_drive, pin_in_enable, pin_pull_up, e, mk;
  logic [17:0] pin_pull_down, gpio_data_out, gpio_dir_out, gpio_high_drive, gpio_data_in;
  logic [17:0] pin_filter_enable, periph_own, periph_out, periph_oe, ext_en, ext_val;
  logic [35:0] gpio_pull_mode, pin_wake_control;
  logic [7:0] debug_select_port0, debug_select_port1;
  logic [15:0] debug_out, debug_oe;
  logic wake_request, master_spi_data_out, master_spi_clock_out, master_spi_select_out;
  logic master_spi_data_in, otp_spi_active, otp_spi_clock_in, otp_spi_select_in;
  logic otp_spi_data_in, otp_spi_data_out, flash_spi_active, flash_spi_clock_out;
  logic flash_spi_select_out, flash_spi_data_out, flash_spi_data_in, radio_spi_active;
  logic radio_spi_clock_in, radio_spi_select_in, radio_spi_data_in, radio_chip_enable_in;
  logic radio_spi_data_out, radio_interrupt_out;
  int fail_count = 0, n_compared = 0, wakes = 0, w0;
  wire [17:0] act_v = {15'h0, radio_spi_active, flash_spi_active, otp_spi_active};
  gpmw_pin_mux dut (.*);
  gpmw_pads pads (.*);
  always #5 sys_clk = ~sys_clk;
  // Count wake pulses
  always @(posedge sys_clk) if (wake_request === 1'b1) wakes <= wakes + 1;
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pins whose two-bit pull code equals c
  function automatic logic [17:0] pl(input logic [35:0] m, input logic [1:0] c);
    for (int i = 0; i < 18; i++) pl[i] = (m[2*i +: 2] == c);
  endfunction
  // Test-mode inputs {otp d,s,c, flash d, radio c,s,d,ce} for code index k
  function automatic logic [7:0] rin(input int k, input logic [17:0] v);
    if (k == 0) rin = {v[7], v[6], v[5], 1'b0, 4'b0100};
    else if (k == 1) rin = {3'b010, v[8], 4'b0100};
    else rin = {3'b010, 1'b0, v[15], v[14], v[13], v[11]};
  endfunction
  task automatic rnd;
    gpio_data_out = 18'($urandom);
    gpio_dir_out = 18'($urandom);
    gpio_high_drive = 18'($urandom);
    gpio_pull_mode = 36'({$urandom, $urandom});
    pin_filter_enable = 18'($urandom);
    periph_own = 18'($urandom & $urandom);
    periph_out = 18'($urandom);
    periph_oe = 18'($urandom);
    ext_val = 18'($urandom);
    {debug_out, debug_oe} = $urandom;
    {master_spi_data_out, master_spi_clock_out, master_spi_select_out, otp_spi_data_out,
      flash_spi_clock_out, flash_spi_select_out, flash_spi_data_out, radio_spi_data_out,
      radio_interrupt_out} = 9'($urandom);
  endtask
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    close_out;
  end
  initial begin
    void'($urandom(20));
    rnd;
    {gpio_dir_out, periph_own, pin_wake_control, pin_filter_enable, debug_select_port0,
      debug_select_port1, master_spi_enable, master_spi_data_oe} = '0;
    ext_en = 18'h3ffff;
    step(4);
    rst = 1'b0;
    step(4);
    chk(pin_oe, 18'h0);
    repeat (40) begin
      rnd;
      step(8);
      mk = ~periph_own;
      e = (periph_own & periph_oe) | (mk & gpio_dir_out);
      chk(pin_oe, e);
      chk(pin_out & e, ((periph_own & periph_out) | (mk & gpio_data_out)) & e);
      chk(pin_high_drive & mk & e, gpio_high_drive & mk & e);
      mk = mk & ~gpio_dir_out;
      chk(pin_pull_up & mk, pl(gpio_pull_mode, 2'h1) & mk);
      chk(pin_pull_down & mk, pl(gpio_pull_mode, 2'h2) & mk);
      chk(pin_in_enable & mk, ~pl(gpio_pull_mode, 2'h3) & mk);
      chk(gpio_data_in, pin_in);
    end
    {gpio_dir_out, periph_own, pin_filter_enable} = '0;
    for (int p = 0; p < 18; p++) begin
      for (int c = 0; c < 4; c++) begin
        pin_wake_control = 36'h0;
        ext_en = 18'h1 << p;
        ext_val = 18'h0;
        step(8);
        pin_wake_control = 36'(c) << (2 * p);
        step(1);
        w0 = wakes;
        ext_val[p] = 1'b1;
        step(8);
        ext_val[p] = 1'b0;
        step(8);
        chk(18'(wakes - w0), 18'(c >> 1));
      end
    end
    ext_en = 18'h3ffff;
    step(8);
    pin_wake_control = 36'h200;
    for (int f = 0; f < 3; f++) begin
      pin_filter_enable = (f > 0) ? 18'h10 : 18'h0;
      w0 = wakes;
      ext_val[4] = 1'b1;
      step((f == 2) ? 6 : 2);
      ext_val[4] = 1'b0;
      step(10);
      chk(18'(wakes - w0), 18'(f != 1));
    end
    repeat (4) begin
      {debug_select_port1, debug_select_port0} = 16'h1 << ($urandom % 16);
      step(1);
      chk(18'(pin_oe[15:0]), 18'(debug_oe));
    end
    {debug_select_port1, debug_select_port0} = 16'h0;
    master_spi_enable = 1'b1;
    for (int m = 0; m < 2; m++) begin
      master_spi_data_oe = 1'(m);
      ext_val[15] = ~ext_val[15];
      step(8);
      chk(18'(pin_oe[15:12]), 18'(3 + 4 * m));
      chk(18'(master_spi_data_in), 18'(ext_val[15]));
    end
    master_spi_enable = 1'b0;
    for (int k = 0; k < 3; k++) begin
      ext_val[17:4] = 14'($urandom);
      ext_val[3:0] = (k == 2) ? 4'h3 : 4'(k);
      test_pin = 1'b1;
      step(900);
      chk(act_v, 18'h0);
      step(200);
      chk(act_v, 18'h1 << k);
      chk(18'({otp_spi_data_in, otp_spi_select_in, otp_spi_clock_in, flash_spi_data_in,
        radio_spi_clock_in, radio_spi_select_in, radio_spi_data_in, radio_chip_enable_in}),
        18'(rin(k, ext_val)));
      if (k == 1) ext_val[3] = 1'b1;
      else test_pin = 1'b0;
      step(5);
      chk(act_v, 18'h0);
      test_pin = 1'b0;
      step(4);
    end
    close_out;
  end
endmodule // test_gpmw_pin_mux
`default_nettype wire
